// ==== smad_consts.vh ====
// Constants for the signed multiply-add-divide datapath.
// Assumes inclusion by bare name from the core; definitions only.
`ifndef SMAD_CONSTS_VH
`define SMAD_CONSTS_VH

// Default operand widths (multiplicand X, multiplier Y)
`define SMAD_XW_DEF 8
`define SMAD_YW_DEF 8

// Operation codes presented on i_op with i_start
`define SMAD_OP_W 3
`define SMAD_OP_MAC 3'h0
`define SMAD_OP_SMAG 3'h1
`define SMAD_OP_OC_CONV 3'h2
`define SMAD_OP_OC_RAW 3'h3
`define SMAD_OP_SQRT 3'h4
`define SMAD_OP_RSS 3'h5
`define SMAD_OP_DIV 3'h6

// Squaring passes of the three-square root (index of the last pass)
`define SMAD_SQ_CNT_W 2
`define SMAD_SQ_LAST 2'h2

// Reset values
`define SMAD_SQ_CNT_RST 2'h0
`define SMAD_FLAG_RST 1'h0

`endif

// ==== smad_core.v ====
// Signed multiply-add array with sign correction, square root and
// rounded two's complement division sequencers.
// Assumes synchronous operands held stable while o_busy is high.
// Assumes XW >= YW >= 3; every result wraps modulo 2^(XW+YW).
// Only the root operand is captured at start; a changing divisor spoils a divide.
//
// Contract
// - Low extra bit gives plain XY plus K
// - High extra bit adds X once more
// - Sign-magnitude corrections added at upper weights
// - Converted one's complement correction by sign pair
// - Unit weight correction enters through addend
// - Raw one's complement conditional adder correction
// - Unequal lengths use sign-extended conditional adder
// - Square root by squaring trial and comparing
// - Root of three squares reuses array
// - Division in two's complement, first trial minus one
// - Sign digit from minus half divisor test
// - Other digits from trial times divisor test
// - Register top bit presented inverted to array
// - Comparator swaps product and dividend sign bits
// - Half divisor term rounds the quotient
`timescale 1ns/100ps
`default_nettype none
`include "smad_consts.vh"

module smad_core #(
  parameter XW = `SMAD_XW_DEF,
  parameter YW = `SMAD_YW_DEF
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_start,
  input wire [`SMAD_OP_W-1:0] i_op,
  input wire i_ym1,
  input wire [XW-1:0] i_x,
  input wire [YW-1:0] i_y,
  input wire [YW-1:0] i_z,
  input wire [YW-1:0] i_w,
  input wire [XW+YW-1:0] i_k,
  output reg [XW+YW-1:0] o_result,
  output reg o_done,
  output reg o_busy
);

  localparam PW = XW + YW;

  // One-hot sequencer states
  // One-hot codes, but each state test compares all three bits
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ACC = 3'h2;
  localparam [2:0] ST_BITS = 3'h4;

  // The array itself: x*y + y_minus_one*x + k, modulo 2^PW
  // Every mode goes through this one function so all share the same wrap
  function [PW-1:0] arr;
    input [XW-1:0] ax;
    input [YW-1:0] ay;
    input aym1;
    input [PW-1:0] ak;
    reg [PW-1:0] xe;
    reg [PW-1:0] ye;
    begin
      xe = {{YW{ax[XW-1]}}, ax};
      ye = {{XW{ay[YW-1]}}, ay};
      arr = xe * ye + (aym1 ? xe : {PW{1'h0}}) + ak;
    end
  endfunction

  // Signed a < b done as unsigned compare with the sign bits crossed
  // Crossing the signs saves a separate signed comparator
  function cmp_lt;
    input [PW-1:0] a;
    input [PW-1:0] b;
    begin
      cmp_lt = ({b[PW-1], a[PW-2:0]} < {a[PW-1], b[PW-2:0]});
    end
  endfunction

  // Sequencer registers
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`SMAD_OP_W-1:0] op_r;
  reg [`SMAD_OP_W-1:0] op_nxt;
  reg [YW-1:0] sar_r;
  reg [YW-1:0] sar_nxt;
  reg [YW-1:0] mask_r;
  reg [YW-1:0] mask_nxt;
  reg [PW-1:0] acc_r;
  reg [PW-1:0] acc_nxt;
  reg [`SMAD_SQ_CNT_W-1:0] sq_cnt_r;
  reg [`SMAD_SQ_CNT_W-1:0] sq_cnt_nxt;
  reg [PW-1:0] result_nxt;
  reg done_nxt;

  // Operand signs, sign extensions and sign-free magnitudes
  wire x_sign = i_x[XW-1];
  wire y_sign = i_y[YW-1];
  wire [PW-1:0] x_ext = {{YW{x_sign}}, i_x};
  wire [PW-1:0] y_ext = {{XW{y_sign}}, i_y};
  wire [PW-1:0] x_mag = {{(YW+1){1'h0}}, i_x[XW-2:0]};
  wire [PW-1:0] y_mag = {{(XW+1){1'h0}}, i_y[YW-2:0]};
  wire [PW-1:0] one_pw = {{(PW-1){1'h0}}, 1'h1};

  // Single-step results of the multiply modes
  reg [PW-1:0] mac_val;
  reg [PW-1:0] smag_val;
  reg [PW-1:0] oc_conv_val;
  reg [PW-1:0] oc_raw_val;
  reg [PW-1:0] smag_base;
  reg [PW-1:0] oc_corr;
  reg [PW-1:0] x_ones;
  reg [PW-1:0] y_ones;
  always @* begin
    // extra bit low, XY plus K
    mac_val = arr(i_x, i_y, i_ym1, i_k);
    // upper-weight sign corrections
    // Output adders cover the high weights; K is still added on the end
    smag_base = arr(i_x, i_y, 1'h0, {PW{1'h0}});
    case ({x_sign, y_sign})
      2'h0: smag_val = smag_base;
      2'h2: smag_val = {PW{1'h0}} - smag_base - (y_mag << (XW - 1));
      2'h1: smag_val = {PW{1'h0}} - smag_base - (x_mag << (YW - 1));
      default: smag_val = smag_base - (one_pw << (PW - 2)) + (x_mag << (YW - 1))
        + (y_mag << (XW - 1));
    endcase
    smag_val = smag_val + i_k;
    // converted operands, correction 0, Y, X or X+Y+1
    oc_corr = (x_sign ? y_ext : {PW{1'h0}}) + (y_sign ? x_ext : {PW{1'h0}})
      + ((x_sign & y_sign) ? one_pw : {PW{1'h0}});
    oc_conv_val = arr(i_x, i_y, 1'h0, i_k + oc_corr);
    // sign-extended one's complement values of both lengths
    x_ones = x_ext + {{(PW-1){1'h0}}, x_sign};
    y_ones = y_ext + {{(PW-1){1'h0}}, y_sign};
    // conditional adder, minus one when both signs set
    oc_corr = (x_sign ? y_ones : {PW{1'h0}}) + (y_sign ? x_ones : {PW{1'h0}})
      - ((x_sign & y_sign) ? one_pw : {PW{1'h0}});
    oc_raw_val = arr(i_x, i_y, 1'h0, i_k + oc_corr);
  end

  // Trial values and comparisons for the sequenced modes
  reg [YW-1:0] trial_sq;
  reg [YW-1:0] trial_dv;
  reg [YW-1:0] trial_raw;
  reg [PW-1:0] sq_val;
  reg [PW-1:0] dv_val;
  reg [PW-1:0] half_dv;
  reg [YW-1:0] sq_pick;
  reg [PW-1:0] acc_sq;
  reg bit_keep;
  always @* begin
    // Root trial sets the bit under test; top bit stays zero so it is positive
    trial_sq = sar_r | mask_r;
    sq_val = arr({{(XW-YW){1'h0}}, trial_sq}, trial_sq, 1'h0, {PW{1'h0}});
    // Decided bits, bit under test at 0 and ones below it: the trial sits
    // one step under the candidate, which the half divisor then splits
    trial_raw = sar_r | (mask_r - {{(YW-1){1'h0}}, 1'h1});
    // inverted top bit, cleared register reads as -1
    trial_dv = {~trial_raw[YW-1], trial_raw[YW-2:0]};
    // half divisor rounds the quotient
    // Arithmetic halving; an odd divisor loses half an LSB of the offset
    half_dv = {{(YW+1){i_x[XW-1]}}, i_x[XW-1:1]};
    dv_val = arr(i_x, trial_dv, 1'h0, half_dv);
    if (op_r == `SMAD_OP_DIV) begin
      // sign digit polarity set by divisor sign
      // crossed-sign compare against the double-length dividend
      bit_keep = cmp_lt(dv_val, i_k) ^ i_x[XW-1];
    end else begin
      // keep the bit while the square is smaller
      bit_keep = cmp_lt(sq_val, acc_r);
    end
    // squares of the three inputs accumulate through K
    case (sq_cnt_r)
      2'h0: sq_pick = i_y;
      2'h1: sq_pick = i_z;
      default: sq_pick = i_w;
    endcase
    acc_sq = arr({{(XW-YW){sq_pick[YW-1]}}, sq_pick}, sq_pick, 1'h0, acc_r);
  end

  // Sequencer next state
  // Defaults hold every register but done, which drops to 0, so each state names only what moves
  always @* begin
    state_nxt = state_r;
    op_nxt = op_r;
    sar_nxt = sar_r;
    mask_nxt = mask_r;
    acc_nxt = acc_r;
    sq_cnt_nxt = sq_cnt_r;
    result_nxt = o_result;
    done_nxt = 1'h0;
    case (state_r)
      ST_IDLE: begin
        // Starts while busy are ignored since only idle looks at them
        if (i_start) begin
          op_nxt = i_op;
          sar_nxt = {YW{1'h0}};
          sq_cnt_nxt = `SMAD_SQ_CNT_RST;
          acc_nxt = {PW{1'h0}};
          case (i_op)
            `SMAD_OP_MAC: begin
              result_nxt = mac_val;
              done_nxt = 1'h1;
            end
            `SMAD_OP_SMAG: begin
              result_nxt = smag_val;
              done_nxt = 1'h1;
            end
            `SMAD_OP_OC_CONV: begin
              result_nxt = oc_conv_val;
              done_nxt = 1'h1;
            end
            `SMAD_OP_OC_RAW: begin
              result_nxt = oc_raw_val;
              done_nxt = 1'h1;
            end
            `SMAD_OP_SQRT: begin
              // root top bit kept 0, so testing starts one bit lower
              acc_nxt = i_k;
              mask_nxt = {2'h1, {(YW-2){1'h0}}};
              state_nxt = ST_BITS;
            end
            `SMAD_OP_RSS: begin
              state_nxt = ST_ACC;
            end
            `SMAD_OP_DIV: begin
              mask_nxt = {1'h1, {(YW-1){1'h0}}};
              state_nxt = ST_BITS;
            end
            default: begin
              // Unused codes finish at once and leave the result alone
              done_nxt = 1'h1;
            end
          endcase
        end
      end
      ST_ACC: begin
        // three squaring passes through K, then the root bits
        acc_nxt = acc_sq;
        sq_cnt_nxt = sq_cnt_r + 2'h1;
        if (sq_cnt_r == `SMAD_SQ_LAST) begin
          mask_nxt = {2'h1, {(YW-2){1'h0}}};
          state_nxt = ST_BITS;
        end
      end
      ST_BITS: begin
        // one bit per step, done after the last
        sar_nxt = sar_r | (bit_keep ? mask_r : {YW{1'h0}});
        mask_nxt = mask_r >> 1;
        if (mask_r[0]) begin
          state_nxt = ST_IDLE;
          done_nxt = 1'h1;
          // Presented top bit is the quotient sign, copied over the top half
          if (op_r == `SMAD_OP_DIV)
            result_nxt = {{XW{~sar_nxt[YW-1]}}, ~sar_nxt[YW-1], sar_nxt[YW-2:0]};
          else
            result_nxt = {{XW{1'h0}}, sar_nxt};
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State and output registers; reset clears the approximation register
  // Reset loads constants only; every other load waits for the clock
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      op_r <= `SMAD_OP_MAC;
      sar_r <= {YW{1'h0}};
      mask_r <= {YW{1'h0}};
      acc_r <= {PW{1'h0}};
      sq_cnt_r <= `SMAD_SQ_CNT_RST;
      o_result <= {PW{1'h0}};
      o_done <= `SMAD_FLAG_RST;
      o_busy <= `SMAD_FLAG_RST;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      sar_r <= sar_nxt;
      mask_r <= mask_nxt;
      acc_r <= acc_nxt;
      sq_cnt_r <= sq_cnt_nxt;
      o_result <= result_nxt;
      o_done <= done_nxt;
      o_busy <= (state_nxt != ST_IDLE); // Busy flags the next state
    end
  end

endmodule

`default_nettype wire

// ==== smad_asserts.sv ====
// Port checker for the multiply-add-divide core.
// Assumes one clock and an async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module smad_asserts #(parameter XW = 8, parameter YW = 8) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [2:0] i_op,
  input wire logic i_ym1,
  input wire logic [XW-1:0] i_x,
  input wire logic [YW-1:0] i_y,
  input wire logic [YW-1:0] i_z,
  input wire logic [YW-1:0] i_w,
  input wire logic [XW+YW-1:0] i_k,
  input wire logic [XW+YW-1:0] o_result,
  input wire logic o_done,
  input wire logic o_busy
);
  localparam PW = XW + YW;
  // Expected one-cycle results, all modulo 2^PW
  wire go = i_start && !o_busy;
  wire xs = i_x[XW-1];
  wire ys = i_y[YW-1];
  wire [PW-1:0] sx = $signed(i_x);
  wire [PW-1:0] sy = $signed(i_y);
  wire [PW-1:0] mg = i_x[XW-2:0] * i_y[YW-2:0];
  wire [PW-1:0] mac = sx * sy + i_k + (i_ym1 ? sx : {PW{1'b0}});
  wire [PW-1:0] smg = ((xs ^ ys) ? -mg : mg) + i_k;
  wire [PW-1:0] occ = (sx + xs) * (sy + ys) + i_k;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  // Sequenced ops end with done up and busy already down
  sequence s_end;
    o_done && !o_busy;
  endsequence
  a_mac_plain: assert property (go && i_op == 3'h0 && !i_ym1 |=>
    o_done && o_result == $past(mac)) else $error("plain sum wrong");
  a_mac_extra: assert property (go && i_op == 3'h0 && i_ym1 |=>
    o_result == $past(mac)) else $error("extra sum wrong");
  a_smag_corr: assert property (go && i_op == 3'h1 |=>
    o_result == $past(smg)) else $error("signed magnitude wrong");
  a_oc_conv: assert property (go && i_op == 3'h2 |=>
    o_result == $past(occ)) else $error("ones product wrong");
  a_sqrt_seq: assert property (go && i_op == 3'h4 |=>
    o_busy[*6] ##[1:3] s_end) else $error("root timing wrong");
  a_rss_seq: assert property (go && i_op == 3'h5 |=>
    o_busy[*8] ##[2:5] s_end) else $error("triple root timing wrong");
  a_div_seq: assert property (go && i_op == 3'h6 |=>
    o_busy[*7] ##[1:3] s_end) else $error("divide timing wrong");
  a_res_hold: assert property (!o_done |-> $stable(o_result))
    else $error("result moved early");
endmodule
bind smad_core smad_asserts #(.XW(XW), .YW(YW)) u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_start(i_start), .i_op(i_op), .i_ym1(i_ym1), .i_x(i_x), .i_y(i_y), .i_z(i_z),
  .i_w(i_w), .i_k(i_k), .o_result(o_result), .o_done(o_done), .o_busy(o_busy));
`default_nettype wire

// ==== smad_acc.sv ====
// Result register of the surrounding datapath, fed back for stepped use.
// Assumes the core's done pulse marks a valid result.
`timescale 1ns/100ps
`default_nettype none
module smad_acc #(parameter PW = 16) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_done,
  input wire logic [PW-1:0] i_result,
  output logic [PW-1:0] o_acc
);
  // cleared, then loaded
  // Clearing first lets step one add only the leading constant
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_acc <= {PW{1'b0}};
    else if (i_done)
      o_acc <= i_result;
  end
endmodule
`default_nettype wire

// ==== smad_core_tb.sv ====
// Self-checking bench for the multiply-add-divide core.
// Assumes the core, result register model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module smad_core_tb;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  logic i_ym1 = 1'b0;
  logic [2:0] i_op = 3'h0;
  logic [7:0] i_x = 8'h00;
  logic [7:0] i_y = 8'h00;
  logic [7:0] i_z = 8'h00;
  logic [7:0] i_w = 8'h00;
  logic [15:0] i_k = 16'h0000;
  wire [15:0] o_result;
  wire [15:0] acc;
  wire o_done;
  wire o_busy;
  int error_cnt = 0;
  int checked = 0;
  // 125 MHz clock
  always #4 i_mclk = ~i_mclk;
  smad_core uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_start(i_start), .i_op(i_op),
    .i_ym1(i_ym1), .i_x(i_x), .i_y(i_y), .i_z(i_z), .i_w(i_w), .i_k(i_k),
    .o_result(o_result), .o_done(o_done), .o_busy(o_busy));
  smad_acc u_acc (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_done(o_done),
    .i_result(o_result), .o_acc(acc));
  task automatic stop_test;
    $display("checked %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One op: operands held until done, which is waited for with a bound
  task automatic rc(input string nm, input logic [2:0] op, input logic [7:0] x,
      input logic [7:0] y, input logic [15:0] k, input logic [15:0] ex);
    int n = 0;
    i_op = op;
    i_x = x;
    i_y = y;
    i_k = k;
    i_start = 1'b1;
    @(negedge i_mclk);
    i_start = 1'b0;
    while (o_done !== 1'b1 && n < 20) begin
      @(negedge i_mclk);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      stop_test();
    end
    chk(nm, ex, o_result);
  endtask
  task automatic t_mul;
    int xv;
    int yv;
    rc("mac", 3'h0, 8'hFD, 8'h07, 16'h0100, 16'h00EB);
    i_ym1 = 1'b1;
    rc("mac_x", 3'h0, 8'hFD, 8'h07, 16'h0100, 16'h00E8);
    i_ym1 = 1'b0;
    for (int s = 0; s < 4; s++) begin
      rc("smag", 3'h1, {s[1], 7'h05}, {s[0], 7'h03}, 16'h0000,
        (s == 1 || s == 2) ? 16'hFFF1 : 16'h000F);
      xv = s[1] ? -5 : 5;
      yv = s[0] ? -3 : 3;
      rc("ones", 3'h2, xv[7:0], yv[7:0], 16'h0010, 16'((xv + s[1]) * (yv + s[0]) + 16));
    end
    rc("raw", 3'h3, 8'h05, 8'hFC, 16'h0000, 16'hFFF1);
    $display("multiply test over");
  endtask
  task automatic t_root;
    rc("root", 3'h4, 8'h00, 8'h00, 16'h0032, 16'h0007);
    rc("root_sq", 3'h4, 8'h00, 8'h00, 16'h0031, 16'h0006);
    rc("root_top", 3'h4, 8'h00, 8'h00, 16'h3FFF, 16'h007F);
    i_z = 8'h04;
    i_w = 8'h0C;
    rc("rss", 3'h5, 8'h00, 8'h03, 16'h0000, 16'h000C);
    $display("root test over");
  endtask
  // Quotients round to nearest; truncation would give 5 and -5
  task automatic t_div;
    rc("div_pp", 3'h6, 8'h04, 8'h00, 16'h0017, 16'h0006);
    rc("div_np", 3'h6, 8'h04, 8'h00, 16'hFFE9, 16'hFFFA);
    rc("div_pn", 3'h6, 8'hFC, 8'h00, 16'h0017, 16'hFFFA);
    rc("div_nn", 3'h6, 8'hFC, 8'h00, 16'hFFE9, 16'h0006);
    rc("div_m1", 3'h6, 8'h04, 8'h00, 16'hFFFD, 16'hFFFF);
    rc("nop", 3'h7, 8'h00, 8'h00, 16'h0000, 16'hFFFF);
    $display("divide test over");
  endtask
  task automatic t_poly;
    i_rst_n = 1'b0;
    @(negedge i_mclk);
    chk("rst", 16'h0000, o_result);
    i_rst_n = 1'b1;
    rc("p1", 3'h0, acc[7:0], 8'h03, 16'h0002, 16'h0002);
    // Let the result register load before it is fed back
    @(negedge i_mclk);
    rc("p2", 3'h0, acc[7:0], 8'h03, 16'h0003, 16'h0009);
    @(negedge i_mclk);
    rc("p3", 3'h0, acc[7:0], 8'h03, 16'h0005, 16'h0020);
    $display("polynomial test over");
  endtask
  initial begin
    repeat (16) @(negedge i_mclk);
    i_rst_n = 1'b1;
    t_mul();
    t_root();
    t_div();
    t_poly();
    stop_test();
  end
endmodule
`default_nettype wire
